// File: plx_defines.vh
// Purpose: constants for the pcs auxiliary test, low power and fiber block
// Assumes: register indices are word indices, byte address is four times index
// Notes: register layout and values chosen for this block
`ifndef PLX_DEFINES_VH
`define PLX_DEFINES_VH

// register word indices
`define PLX_IDX_CTRL 4'h0
`define PLX_IDX_TSTPAT 4'h1
`define PLX_IDX_LPI_CFG 4'h2
`define PLX_IDX_LPI_STAT 4'h3
`define PLX_IDX_WAKE_CNT 4'h4
`define PLX_IDX_FX_CFG 4'h5
`define PLX_IDX_FX_STAT 4'h6
`define PLX_IDX_TP_STAT 4'h7

// control register fields
`define PLX_CTRL_LOOP 0
// lpi config fields
`define PLX_LPI_FORCE 0
// lpi status fields
`define PLX_LS_RX_MODE 0
`define PLX_LS_RX_QUIET 1
`define PLX_LS_RX_SEEN 2
`define PLX_LS_TX_MODE 4
`define PLX_LS_TX_QUIET 5
`define PLX_LS_TX_SENT 6
// fiber config fields
`define PLX_FX_ENA 0
`define PLX_FX_FEF_GEN 1
`define PLX_FX_FEF_CHK 2
`define PLX_FX_LOS_DETECT_ENABLE 3
`define PLX_FX_LOS_DETECT_POLARITY 4
`define PLX_FX_LOS_DETECT_SOURCE 5
`define PLX_FX_UNIDIR 6
// fiber status fields
`define PLX_FS_FEF 0
`define PLX_FS_SIGDET 1
`define PLX_FS_SYNC 2
`define PLX_FS_SYNC_LOST 3
// test pattern status fields
`define PLX_TP_LOCK 0
`define PLX_TP_ERR 1

// jitter pattern selections
`define PLX_JTP_OFF 3'h0
`define PLX_JTP_HIGH 3'h1
`define PLX_JTP_LOW 3'h2
`define PLX_JTP_MIXED 3'h3
`define PLX_JTP_RND_LONG 3'h4
`define PLX_JTP_RND_SHORT 3'h5

// code groups (10 bit)
`define PLX_CG_HIGH 10'h155
`define PLX_CG_LOW 10'h01f
`define PLX_CG_MIXED 10'h0fa
`define PLX_CG_LPI 10'h2a5
`define PLX_CG_IDLE 10'h283
`define PLX_CG_QUIET 10'h000
// 4b5b special codes
`define PLX_FX_IDLE5 5'h1f
`define PLX_FX_FEF5 5'h1f

// lpi timing: quiet for 2000 cycles between refreshes lasting 20 cycles
`define PLX_LPI_QUIET_CYC 12'h7d0
`define PLX_LPI_REFR_CYC 12'h014
// lock needs 16 matching groups
`define PLX_TP_LOCK_CNT 5'h10

`endif

// File: plx_pcs_aux.v
// Purpose: loopback, jitter patterns, low power idle and fiber mode of one pcs port
// Assumes: all inputs synchronous to clk; registers over a simple strobe port
// Notes: read data valid one cycle after the read strobe only
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "plx_defines.vh"

// Behaviour
// - host loop enable routes transmit path back into receive path.
// - jitter select 1 to 5 overrides gigabit traffic with the test pattern.
// - five patterns: high, low, mixed, random long and random short frames.
// - test pattern status reports error and lock while pattern runs.
// - low power idle passes between mac and code groups both ways.
// - serdes transmit stop control for quiet, resumed for refresh.
// - low power entry and exit driven by the queue system request.
// - force bit enters transmit low power idle regardless of queue.
// - in low power idle transmit lpi encoding with periodic refresh.
// - receive low power status reads one while lpi or quiet groups arrive.
// - receive quiet bit one in quiet; zero with mode means refresh.
// - transmit mode and quiet bits report like the receive ones.
// - sticky flags set on received and on transmitted lpi symbol.
// - wake error counter counts signal present while not synchronized.
// - fiber mode codes data with 4b/5b blocks.
// - fiber enable activates fiber mode and masks gigabit registers.
// - separate enables for far fault generation and detection.
// - received far fault with detection enabled sets found bit.
// - fiber signal detect enable, polarity, source; live status bit.
// - live sync status; sync loss drops link, sets sticky, keeps retrying.
// - fiber one way enable allows unidirectional operation.
// - enabled signal loss restarts receive and stops frame reception.
// - one way mode transmits regardless of receive link state.
module plx_pcs_aux (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [7:0] mac_tx_data,
    input wire mac_tx_lpi,
    input wire queue_lpi_req,
    output reg [7:0] mac_rx_data,
    output reg mac_rx_lpi,
    output reg mac_rx_valid,
    output reg [9:0] ser_tx_group,
    output reg ser_tx_stop,
    input wire [9:0] ser_rx_group,
    input wire ser_rx_sync,
    input wire pma_sig_det,
    input wire pmd_sig_det,
    output reg link_up
);

    // software registers
    reg loop_reg;
    reg [2:0] jtp_reg;
    reg force_lpi_reg;
    reg [6:0] fx_cfg_reg;
    reg rx_seen_reg;
    reg tx_sent_reg;
    reg far_fault_detected_reg;
    reg sync_lost_reg;
    reg [31:0] wake_cnt_reg;
    // transmit low power state
    reg tx_lpi_reg;
    reg tx_quiet_reg;
    reg [11:0] lpi_cnt_reg;
    // test pattern generator and checker
    reg [9:0] prbs_reg;
    reg [9:0] prbs_dly_reg;
    reg [4:0] tp_match_reg;
    reg tp_err_reg;
    reg [9:0] tx_word;
    reg tx_stop_next;
    wire [9:0] rx_word;
    wire sig_raw;
    wire sig_ok;
    wire rx_is_lpi;
    wire rx_is_quiet;
    wire fx_ena;
    wire tx_lpi_want;
    wire tp_expect_ok;
    wire tp_locked;
    wire tp_restart;
    wire rx_low_power_active;

    // 4b/5b encoder nibble to five bit code
    function [4:0] enc45;
        input [3:0] n;
        begin
            case (n)
                4'h0: enc45 = 5'h1e;
                4'h1: enc45 = 5'h09;
                4'h2: enc45 = 5'h14;
                4'h3: enc45 = 5'h15;
                4'h4: enc45 = 5'h0a;
                4'h5: enc45 = 5'h0b;
                4'h6: enc45 = 5'h0e;
                4'h7: enc45 = 5'h0f;
                4'h8: enc45 = 5'h12;
                4'h9: enc45 = 5'h13;
                4'ha: enc45 = 5'h16;
                4'hb: enc45 = 5'h17;
                4'hc: enc45 = 5'h1a;
                4'hd: enc45 = 5'h1b;
                4'he: enc45 = 5'h1c;
                default: enc45 = 5'h1d;
            endcase
        end
    endfunction

    // 4b/5b decoder five bit code to nibble
    function [3:0] dec54;
        input [4:0] c;
        begin
            case (c)
                5'h09: dec54 = 4'h1;
                5'h14: dec54 = 4'h2;
                5'h15: dec54 = 4'h3;
                5'h0a: dec54 = 4'h4;
                5'h0b: dec54 = 4'h5;
                5'h0e: dec54 = 4'h6;
                5'h0f: dec54 = 4'h7;
                5'h12: dec54 = 4'h8;
                5'h13: dec54 = 4'h9;
                5'h16: dec54 = 4'ha;
                5'h17: dec54 = 4'hb;
                5'h1a: dec54 = 4'hc;
                5'h1b: dec54 = 4'hd;
                5'h1c: dec54 = 4'he;
                5'h1d: dec54 = 4'hf;
                default: dec54 = 4'h0;
            endcase
        end
    endfunction

    // expected pattern word for a selection
    function [9:0] tp_word;
        input [2:0] sel;
        input [9:0] prbs;
        begin
            case (sel)
                `PLX_JTP_HIGH: tp_word = `PLX_CG_HIGH;
                `PLX_JTP_LOW: tp_word = `PLX_CG_LOW;
                `PLX_JTP_MIXED: tp_word = `PLX_CG_MIXED;
                `PLX_JTP_RND_LONG: tp_word = prbs;
                `PLX_JTP_RND_SHORT: tp_word = {prbs[9:2], 2'h0};
                default: tp_word = `PLX_CG_IDLE;
            endcase
        end
    endfunction

    assign fx_ena = fx_cfg_reg[`PLX_FX_ENA];
    // receive side source: loopback or line
    assign rx_word = loop_reg ? ser_tx_group : ser_rx_group;
    // signal detect source and polarity
    assign sig_raw = fx_cfg_reg[`PLX_FX_LOS_DETECT_SOURCE] ? pmd_sig_det : pma_sig_det;
    assign sig_ok = sig_raw ^ fx_cfg_reg[`PLX_FX_LOS_DETECT_POLARITY];
    assign rx_is_lpi = rx_word == `PLX_CG_LPI;
    assign rx_is_quiet = rx_word == `PLX_CG_QUIET;
    // queue request, mac request or force bit, gigabit only
    assign tx_lpi_want = !fx_ena && (queue_lpi_req || mac_tx_lpi || force_lpi_reg);
    // the sent word is registered, so compare against last cycle's generator state
    assign tp_expect_ok = rx_word == tp_word(jtp_reg, prbs_dly_reg);
    // lock after enough matching groups in a row
    assign tp_locked = tp_match_reg == `PLX_TP_LOCK_CNT;
    // a new selection restarts the lock so switching is not an error
    assign tp_restart = reg_wr && reg_addr == `PLX_IDX_TSTPAT;
    // receiver in low power idle while lpi or quiet groups arrive
    assign rx_low_power_active = rx_is_lpi || rx_is_quiet;

    // transmit word selection
    always @* begin
        tx_stop_next = 1'b0;
        if (fx_ena) begin
            // one way mode keeps data flowing while the receive link is down
            if (fx_cfg_reg[`PLX_FX_FEF_GEN] && !ser_rx_sync && !fx_cfg_reg[`PLX_FX_UNIDIR])
                tx_word = {`PLX_FX_FEF5, `PLX_FX_FEF5};
            else
                tx_word = {enc45(mac_tx_data[7:4]), enc45(mac_tx_data[3:0])};
        end else if (jtp_reg != `PLX_JTP_OFF) begin
            tx_word = tp_word(jtp_reg, prbs_reg);
        end else if (tx_lpi_reg) begin
            tx_word = tx_quiet_reg ? `PLX_CG_QUIET : `PLX_CG_LPI;
            tx_stop_next = tx_quiet_reg;
        end else begin
            // gigabit traffic: byte in the upper bits, low bits unused
            tx_word = {mac_tx_data, 2'h0};
        end
    end

    // transmit low power sequencer: refresh then quiet periods
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_lpi_reg <= 1'b0;
            tx_quiet_reg <= 1'b0;
            lpi_cnt_reg <= 12'h000;
        end else if (!tx_lpi_want) begin
            tx_lpi_reg <= 1'b0;
            tx_quiet_reg <= 1'b0;
            lpi_cnt_reg <= 12'h000;
        end else if (!tx_lpi_reg) begin
            tx_lpi_reg <= 1'b1;
            lpi_cnt_reg <= 12'h000;
        end else if (tx_quiet_reg ? (lpi_cnt_reg == `PLX_LPI_QUIET_CYC - 12'h001)
                                  : (lpi_cnt_reg == `PLX_LPI_REFR_CYC - 12'h001)) begin
            tx_quiet_reg <= !tx_quiet_reg;
            lpi_cnt_reg <= 12'h000;
        end else begin
            lpi_cnt_reg <= lpi_cnt_reg + 12'h001;
        end
    end

    // line outputs and receive path
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ser_tx_group <= `PLX_CG_IDLE;
            ser_tx_stop <= 1'b0;
            mac_rx_data <= 8'h00;
            mac_rx_lpi <= 1'b0;
            mac_rx_valid <= 1'b0;
            link_up <= 1'b0;
        end else begin
            ser_tx_group <= tx_word;
            ser_tx_stop <= tx_stop_next;
            link_up <= ser_rx_sync && (sig_ok || !fx_cfg_reg[`PLX_FX_LOS_DETECT_ENABLE]);
            // lost signal with detect enabled stops reception at once
            if (fx_cfg_reg[`PLX_FX_LOS_DETECT_ENABLE] && !sig_ok) begin
                mac_rx_valid <= 1'b0;
                mac_rx_lpi <= 1'b0;
            end else if (fx_ena) begin
                mac_rx_data <= {dec54(rx_word[9:5]), dec54(rx_word[4:0])};
                mac_rx_valid <= ser_rx_sync;
                mac_rx_lpi <= 1'b0;
            end else begin
                mac_rx_data <= rx_word[9:2];
                mac_rx_lpi <= rx_low_power_active;
                mac_rx_valid <= ser_rx_sync && !rx_low_power_active;
            end
        end
    end

    // pattern generator and checker
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prbs_reg <= 10'h3ff;
            prbs_dly_reg <= 10'h3ff;
            tp_match_reg <= 5'h00;
            tp_err_reg <= 1'b0;
        end else begin
            prbs_reg <= {prbs_reg[8:0], prbs_reg[9] ^ prbs_reg[6]};
            prbs_dly_reg <= prbs_reg;
            // clear first so an error in the same cycle still sets the flag
            if (reg_wr && reg_addr == `PLX_IDX_TP_STAT && reg_wdata[`PLX_TP_ERR])
                tp_err_reg <= 1'b0;
            if (jtp_reg == `PLX_JTP_OFF || fx_ena || tp_restart) begin
                tp_match_reg <= 5'h00;
            end else if (tp_expect_ok) begin
                if (!tp_locked)
                    tp_match_reg <= tp_match_reg + 5'h01;
            end else begin
                tp_match_reg <= 5'h00;
                if (tp_locked)
                    tp_err_reg <= 1'b1;
            end
        end
    end

    // software registers, sticky flags and counter; set wins over clear
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_reg <= 1'b0;
            jtp_reg <= 3'h0;
            force_lpi_reg <= 1'b0;
            fx_cfg_reg <= 7'h00;
            rx_seen_reg <= 1'b0;
            tx_sent_reg <= 1'b0;
            far_fault_detected_reg <= 1'b0;
            sync_lost_reg <= 1'b0;
            wake_cnt_reg <= 32'h0;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `PLX_IDX_CTRL: if (!fx_ena) loop_reg <= reg_wdata[`PLX_CTRL_LOOP];
                    `PLX_IDX_TSTPAT: if (!fx_ena) jtp_reg <= reg_wdata[2:0];
                    `PLX_IDX_LPI_CFG: if (!fx_ena) force_lpi_reg <= reg_wdata[`PLX_LPI_FORCE];
                    `PLX_IDX_FX_CFG: fx_cfg_reg <= reg_wdata[6:0];
                    `PLX_IDX_LPI_STAT: begin
                        if (reg_wdata[`PLX_LS_RX_SEEN]) rx_seen_reg <= 1'b0;
                        if (reg_wdata[`PLX_LS_TX_SENT]) tx_sent_reg <= 1'b0;
                    end
                    `PLX_IDX_FX_STAT: begin
                        if (reg_wdata[`PLX_FS_FEF]) far_fault_detected_reg <= 1'b0;
                        if (reg_wdata[`PLX_FS_SYNC_LOST]) sync_lost_reg <= 1'b0;
                    end
                    `PLX_IDX_WAKE_CNT: wake_cnt_reg <= 32'h0;
                    default: ;
                endcase
            end
            // event sets come after the clears so a same-cycle event wins
            if (!fx_ena && rx_is_lpi)
                rx_seen_reg <= 1'b1;
            if (!fx_ena && tx_word == `PLX_CG_LPI)
                tx_sent_reg <= 1'b1;
            if (fx_ena && fx_cfg_reg[`PLX_FX_FEF_CHK] && rx_word == {`PLX_FX_FEF5, `PLX_FX_FEF5})
                far_fault_detected_reg <= 1'b1;
            if (fx_ena && link_up && !ser_rx_sync)
                sync_lost_reg <= 1'b1;
            // saturate so a long outage never wraps back to a small count
            if (!fx_ena && sig_ok && !ser_rx_sync && wake_cnt_reg != 32'hffffffff)
                wake_cnt_reg <= wake_cnt_reg + 32'h1;
        end
    end

    // read data, one cycle after strobe; zero otherwise
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `PLX_IDX_CTRL: reg_rdata <= {31'h0, loop_reg};
                `PLX_IDX_TSTPAT: reg_rdata <= {29'h0, jtp_reg};
                `PLX_IDX_LPI_CFG: reg_rdata <= {31'h0, force_lpi_reg};
                `PLX_IDX_LPI_STAT: reg_rdata <= {25'h0, tx_sent_reg, tx_quiet_reg, tx_lpi_reg,
                    1'b0, rx_seen_reg, rx_is_quiet, rx_low_power_active};
                `PLX_IDX_WAKE_CNT: reg_rdata <= wake_cnt_reg;
                `PLX_IDX_FX_CFG: reg_rdata <= {25'h0, fx_cfg_reg};
                `PLX_IDX_FX_STAT: reg_rdata <= {28'h0, sync_lost_reg, ser_rx_sync,
                    sig_raw, far_fault_detected_reg};
                `PLX_IDX_TP_STAT: reg_rdata <= {30'h0, tp_err_reg,
                    tp_locked};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule
`default_nettype wire

// File: plx_pcs_aux_asserts.sv
// Purpose: port checker for plx_pcs_aux
// Assumes: one clock, async active high reset
// Notes: shadow config mirrors the design's fiber masking of writes
`timescale 1ns/1ps
`default_nettype none
`include "plx_defines.vh"
module plx_pcs_aux_chk (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire [9:0] ser_tx_group,
    input wire ser_tx_stop,
    input wire ser_rx_sync,
    input wire pma_sig_det,
    input wire pmd_sig_det,
    input wire link_up
);
    reg [2:0] jtp_reg;
    reg [6:0] fx_reg;
    wire sig_ok;
    wire fef_on;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // shadow of pattern select and fiber config
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            jtp_reg <= 3'h0;
            fx_reg <= 7'h00;
        end else if (reg_wr) begin
            if (reg_addr == `PLX_IDX_FX_CFG)
                fx_reg <= reg_wdata[6:0];
            if (reg_addr == `PLX_IDX_TSTPAT && !fx_reg[0])
                jtp_reg <= reg_wdata[2:0];
        end
    end
    // selected and polarity corrected signal detect
    assign sig_ok = (fx_reg[5] ? pmd_sig_det : pma_sig_det) ^ fx_reg[4];
    assign fef_on = fx_reg[0] & fx_reg[1] & !fx_reg[6] & !ser_rx_sync;
    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    chk_rd_unmapped: assert property ($past(reg_rd) && $past(reg_addr[3]) |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_quiet_group: assert property (ser_tx_stop |-> ser_tx_group == `PLX_CG_QUIET)
        else $error("quiet group wrong while stopped");
    chk_quiet_len: assert property ($rose(ser_tx_stop) |-> ser_tx_stop[*8])
        else $error("quiet period too short");
    chk_refresh_first: assert property ($rose(ser_tx_stop) |-> $past(ser_tx_group) == `PLX_CG_LPI)
        else $error("quiet not preceded by lpi refresh");
    chk_link_sync: assert property (link_up |-> $past(ser_rx_sync))
        else $error("link up without sync");
    chk_link_sd: assert property (link_up && $past(fx_reg[0] & fx_reg[3]) |-> $past(sig_ok))
        else $error("link up with signal lost");
    chk_jtp_fixed: assert property ($past(jtp_reg) inside {3'h1, 3'h2, 3'h3} && !$past(fx_reg[0])
        |-> ser_tx_group == ($past(jtp_reg) == 3'h1 ? `PLX_CG_HIGH :
        $past(jtp_reg) == 3'h2 ? `PLX_CG_LOW : `PLX_CG_MIXED))
        else $error("jitter pattern group wrong");
    chk_fef_code: assert property ($past(fef_on) |-> ser_tx_group == 10'h3ff)
        else $error("far fault code not sent");
endmodule
bind plx_pcs_aux plx_pcs_aux_chk chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ser_tx_group(ser_tx_group), .ser_tx_stop(ser_tx_stop), .ser_rx_sync(ser_rx_sync),
    .pma_sig_det(pma_sig_det), .pmd_sig_det(pmd_sig_det), .link_up(link_up));
`default_nettype wire

// File: plx_serdes_model.sv
// Purpose: far side serdes lane model feeding receive groups and status
// Assumes: commands from the bench change just after a rising edge
// Notes: out of sync the lane shows a group that flips every cycle
`timescale 1ns/1ps
`default_nettype none
module plx_serdes_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] rx_kind,
    input wire logic sync_cmd,
    input wire logic sd_cmd,
    output logic [9:0] ser_rx_group,
    output logic ser_rx_sync,
    output logic pma_sig_det,
    output logic pmd_sig_det
);
    // receive group per commanded kind, garbage while unsynchronized
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ser_rx_group <= 10'h283;
        end else if (!sync_cmd) begin
            ser_rx_group <= ~ser_rx_group;
        end else begin
            case (rx_kind)
                2'h1: ser_rx_group <= 10'h2a5;
                2'h2: ser_rx_group <= 10'h000;
                2'h3: ser_rx_group <= 10'h3ff;
                default: ser_rx_group <= 10'h283;
            endcase
        end
    end
    // the two detect sources disagree so source select shows
    assign ser_rx_sync = sync_cmd;
    assign pma_sig_det = sd_cmd;
    assign pmd_sig_det = ~sd_cmd;
endmodule
`default_nettype wire

// File: tb_pcs_lpi_fx_test_extensions.sv
// Purpose: self-checking bench for plx_pcs_aux
// Assumes: 10 MHz clock, register reads answer one cycle later
// Notes: scenarios for patterns, low power idle, wake counter and fiber
`timescale 1ns/1ps
`default_nettype none
`include "plx_defines.vh"
module tb_pcs_lpi_fx_test_extensions;
    logic clk, sys_rst, reg_wr, reg_rd, mac_tx_lpi, queue_lpi_req, ser_rx_sync;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [7:0] mac_tx_data, mac_rx_data;
    logic mac_rx_lpi, mac_rx_valid, ser_tx_stop, pma_sig_det, pmd_sig_det, link_up;
    logic [9:0] ser_tx_group, ser_rx_group, prev;
    logic [1:0] rx_kind;
    logic sync_cmd, sd_cmd;
    int errors, samples_checked, i;
    plx_pcs_aux dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mac_tx_data(mac_tx_data),
        .mac_tx_lpi(mac_tx_lpi), .queue_lpi_req(queue_lpi_req), .mac_rx_data(mac_rx_data),
        .mac_rx_lpi(mac_rx_lpi), .mac_rx_valid(mac_rx_valid), .ser_tx_group(ser_tx_group),
        .ser_tx_stop(ser_tx_stop), .ser_rx_group(ser_rx_group), .ser_rx_sync(ser_rx_sync),
        .pma_sig_det(pma_sig_det), .pmd_sig_det(pmd_sig_det), .link_up(link_up));
    plx_serdes_model far_u (.clk(clk), .sys_rst(sys_rst), .rx_kind(rx_kind), .sync_cmd(sync_cmd),
        .sd_cmd(sd_cmd), .ser_rx_group(ser_rx_group), .ser_rx_sync(ser_rx_sync),
        .pma_sig_det(pma_sig_det), .pmd_sig_det(pmd_sig_det));
    // register bus cycles and waits
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // comparisons
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task cmp_group(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t group got %h exp %h", $time, got, exp);
        end
    endtask
    task cmp_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // watchdog well past the expected run
    initial begin
        #2000000;
        errors++;
        stop_test;
    end
    initial begin
        sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
        mac_tx_data = 8'h00; mac_tx_lpi = 1'b0; queue_lpi_req = 1'b0;
        rx_kind = 2'h0; sync_cmd = 1'b1; sd_cmd = 1'b1;
        errors = 0; samples_checked = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 16; i++) begin
            if (i != 3 && i != 6 && i != 7) begin
                rd(i[3:0]);
                cmp_word(d, 32'h0);
            end
        end
        $display("test reset done");
        // fixed, random and short random patterns
        for (i = 1; i < 6; i++) begin
            wr(`PLX_IDX_TSTPAT, i);
            w(3);
            prev = ser_tx_group;
            if (i < 4)
                cmp_group(ser_tx_group, i == 1 ? `PLX_CG_HIGH : i == 2 ? `PLX_CG_LOW : `PLX_CG_MIXED);
            w(4);
            if (i == 4)
                cmp_flag(ser_tx_group != prev, 1'b1);
            if (i == 5)
                cmp_group({8'h00, ser_tx_group[1:0]}, 10'h000);
        end
        wr(`PLX_IDX_CTRL, 32'h1);
        for (i = 1; i < 6; i += 4) begin
            wr(`PLX_IDX_TSTPAT, i);
            w(40);
            rd(`PLX_IDX_TP_STAT);
            cmp_word(d, 32'h1);
        end
        wr(`PLX_IDX_CTRL, 32'h0);
        rd(`PLX_IDX_TP_STAT);
        cmp_word(d, 32'h2);
        wr(`PLX_IDX_TP_STAT, 32'h2);
        wr(`PLX_IDX_TSTPAT, 32'h0);
        rd(`PLX_IDX_TP_STAT);
        cmp_word(d, 32'h0);
        wr(`PLX_IDX_CTRL, 32'h1);
        mac_tx_data <= 8'h5a;
        w(3);
        cmp_word({mac_rx_valid, 23'h0, mac_rx_data}, 32'h8000005a);
        wr(`PLX_IDX_CTRL, 32'h0);
        $display("test patterns done");
        // transmit lpi from queue, mac and force bit
        for (i = 0; i < 3; i++) begin
            @(posedge clk);
            queue_lpi_req <= (i == 0);
            mac_tx_lpi <= (i == 1);
            if (i == 2)
                wr(`PLX_IDX_LPI_CFG, 32'h1);
            w(3);
            cmp_group(ser_tx_group, `PLX_CG_LPI);
            w(30);
            cmp_flag(ser_tx_stop, 1'b1);
            rd(`PLX_IDX_LPI_STAT);
            cmp_word(d, 32'h70);
            @(posedge clk);
            queue_lpi_req <= 1'b0;
            mac_tx_lpi <= 1'b0;
            wr(`PLX_IDX_LPI_CFG, 32'h0);
            w(5);
            cmp_flag(ser_tx_stop, 1'b0);
            rd(`PLX_IDX_LPI_STAT);
            cmp_word(d, 32'h40);
            wr(`PLX_IDX_LPI_STAT, 32'h40);
            rd(`PLX_IDX_LPI_STAT);
            cmp_word(d, 32'h0);
        end
        // receive lpi, quiet and back to idle
        for (i = 1; i < 4; i++) begin
            @(posedge clk);
            rx_kind <= (i == 3) ? 2'h0 : i[1:0];
            w(4);
            if (i == 1)
                cmp_flag(mac_rx_lpi, 1'b1);
            cmp_flag(mac_rx_valid, i == 3);
            rd(`PLX_IDX_LPI_STAT);
            cmp_word(d, i == 1 ? 32'h5 : i == 2 ? 32'h7 : 32'h4);
        end
        wr(`PLX_IDX_LPI_STAT, 32'h4);
        rd(`PLX_IDX_LPI_STAT);
        cmp_word(d, 32'h0);
        $display("test lpi done");
        // wake errors while signal present and unsynchronized
        @(posedge clk);
        sync_cmd <= 1'b0;
        w(10);
        rd(`PLX_IDX_WAKE_CNT);
        cmp_word(d, 32'hb);
        @(posedge clk);
        sync_cmd <= 1'b1;
        wr(`PLX_IDX_WAKE_CNT, 32'h0);
        rd(`PLX_IDX_WAKE_CNT);
        cmp_word(d, 32'h0);
        $display("test wake done");
        // fiber mode: far fault, coding, masking, signal detect, sync loss
        wr(`PLX_IDX_FX_CFG, 32'h03);
        @(posedge clk);
        sync_cmd <= 1'b0;
        w(3);
        cmp_group(ser_tx_group, 10'h3ff);
        wr(`PLX_IDX_FX_CFG, 32'h43);
        w(3);
        cmp_flag(ser_tx_group != 10'h3ff, 1'b1);
        @(posedge clk);
        sync_cmd <= 1'b1;
        wr(`PLX_IDX_FX_CFG, 32'h01);
        w(3);
        cmp_group(ser_tx_group, 10'h176);
        cmp_flag(link_up, 1'b1);
        wr(`PLX_IDX_CTRL, 32'h1);
        rd(`PLX_IDX_CTRL);
        cmp_word(d, 32'h0);
        for (i = 0; i < 3; i++) begin
            wr(`PLX_IDX_FX_CFG, i == 0 ? 32'h19 : i == 1 ? 32'h29 : 32'h09);
            w(3);
            cmp_flag(link_up, i == 2);
        end
        wr(`PLX_IDX_FX_STAT, 32'h8);
        @(posedge clk);
        sync_cmd <= 1'b0;
        w(3);
        cmp_flag(link_up, 1'b0);
        rd(`PLX_IDX_FX_STAT);
        cmp_word(d & 32'hc, 32'h8);
        @(posedge clk);
        sync_cmd <= 1'b1;
        wr(`PLX_IDX_FX_CFG, 32'h05);
        @(posedge clk);
        rx_kind <= 2'h3;
        w(4);
        rd(`PLX_IDX_FX_STAT);
        cmp_word(d & 32'h7, 32'h7);
        @(posedge clk);
        rx_kind <= 2'h0;
        w(3);
        wr(`PLX_IDX_FX_STAT, 32'h9);
        rd(`PLX_IDX_FX_STAT);
        cmp_word(d & 32'h9, 32'h0);
        $display("test fiber done");
        stop_test;
    end
endmodule
`default_nettype wire
